/* File: rtl/strain_panel_settings.sv */
// settings editor and null sequencer for the strain amplifier front panel
// Behaviour
// - reference value 0 to 9999 microstrain held
// - four decimal digits, each 0 to 9
// - short press starts editor, top digit blinks
// - reference mode lights microstrain indicator
// - option mode darkens microstrain indicator
// - long press toggles reference and option mode
// - rotation changes only the blinking digit
// - short press moves blink one digit lower
// - last digit press stores reference, lights all
// - last digit press stores options, lights all
// - range, injection, null still work while editing
// - reference digit edits reach injection immediately
// - option digits: compensation, wiring, gain codes
// - lowest option digit sets point position
// - null runs wiring, compensation, gain, then null
// - gain only with voltage chosen, range off
// - compensation off clears old compensation on null
// - gain with injection finishes with reference applied
// - no gain: null balances including injection
`timescale 1ns/1ns
`default_nettype none
`include "strain_panel_consts.svh"
module strain_panel_settings #(
   parameter int BLINK_CYCLES = `BLINK_HALF_NS / `CLOCK_PERIOD_NS
) (
   // clock and reset
   input  wire logic                        clock,
   input  wire logic                        sys_rst,
   // operator knob, pulses from the debouncer on this clock
   input  wire strain_panel_pkg::knob_t     knob,
   // null pushbutton pin, asynchronous
   input  wire logic                        null_button,
   // panel switches, asynchronous
   input  wire logic                        range_is_off,
   input  wire logic                        ref_inject_on,
   // stage engine handshake
   input  wire logic                        stage_done,
   output strain_panel_pkg::null_state_t    null_stage,
   output strain_panel_pkg::stage_cmd_t     stage_cmd,
   output logic                             null_busy,
   // settings
   output logic [15:0]                      ref_value,
   output logic [15:0]                      ref_live,
   output logic [15:0]                      option_word,
   output logic                             lead_drop_compensation,
   output logic                             wiring_check,
   output logic [3:0]                       auto_gain_select,
   output logic [1:0]                       point_position,
   // display
   output logic [15:0]                      show_digits,
   output logic [3:0]                       blink_mask,
   output logic                             blink_phase,
   output logic                             unit_lamp,
   output logic                             all_segments,
   output logic [1:0]                       shown_point
);
   // refuse a blink period the counter cannot serve
   if (BLINK_CYCLES < 2) begin : g_blink_check
      $error("BLINK_CYCLES too small");
   end

   // step one bcd digit with wrap inside its legal set
   // used by every reference digit and both option switch digits
   function automatic logic [3:0] step_digit(input logic [3:0] d, input logic up, input logic [3:0] top);
      logic [3:0] r;
      r = d;
      // up past the top wraps to zero; down from zero or a stray code lands on the top
      if (up) r = (d >= top) ? 4'h0 : d + 4'h1;
      else    r = (d == 4'h0 || d > top) ? top : d - 4'h1;
      return r;
   endfunction

   // gain digit walks 0,5,8,1 only
   // the gain code is not ordinal, so it has its own walk
   function automatic logic [3:0] step_gain(input logic [3:0] d, input logic up);
      logic [3:0] r;
      r = `GAIN_OFF;
      // any stray code falls back to off rather than locking up
      unique case (d)
         `GAIN_OFF: r = up ? `GAIN_5V  : `GAIN_10V;
         `GAIN_5V:  r = up ? `GAIN_8V  : `GAIN_OFF;
         `GAIN_8V:  r = up ? `GAIN_10V : `GAIN_5V;
         `GAIN_10V: r = up ? `GAIN_OFF : `GAIN_8V;
         default:   r = `GAIN_OFF;
      endcase
      return r;
   endfunction

   // two-stage synchronisers for the pins
   // bit order: null button, range off, injection on
   // the knob arrives debounced on this clock, so it skips these
   // only the second stage is read; the first may be metastable
   logic [2:0] sync_a;                       // first stage
   logic [2:0] sync_b;                       // second stage
   logic       null_prev;                    // for edge of null button
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync_a    <= 3'h0;
         sync_b    <= 3'h0;
         null_prev <= 1'b0;
      end else begin
         sync_a    <= {null_button, range_is_off, ref_inject_on};
         sync_b    <= sync_a;
         null_prev <= sync_b[2];
      end
   end
   logic null_press;                         // one pulse per press
   assign null_press = sync_b[2] & ~null_prev;

   // editor state
   // one working copy; the stored words change only on a final press
   // digit 3 is the most significant, digit 0 the least
   strain_panel_pkg::editor_t mode, next_mode;
   logic [1:0]  digit, next_digit;           // 3 is the top digit
   logic [15:0] work, next_work;             // digits being edited
   logic [15:0] next_ref_value;
   logic [15:0] next_option_word;
   logic        next_all_segments;

   // next values of the editor
   // priority: long press, then short press, then turn
   // every output gets a default so no latch can form
   always_comb begin
      next_mode         = mode;
      next_digit        = digit;
      next_work         = work;
      next_ref_value    = ref_value;
      next_option_word  = option_word;
      next_all_segments = all_segments;
      unique case (mode)
         strain_panel_pkg::ed_idle: begin
            // long presses and turns are ignored while idle
            if (knob.short_press) begin
               next_mode         = strain_panel_pkg::ed_ref;
               next_digit        = 2'd3;
               next_work         = ref_value;
               next_all_segments = 1'b0;
            end
         end
         default: begin
            if (knob.long_press) begin
               // switch buffer; unstored edits of the mode being left are dropped
               next_mode  = (mode == strain_panel_pkg::ed_ref) ? strain_panel_pkg::ed_opt
                                                               : strain_panel_pkg::ed_ref;
               next_work  = (mode == strain_panel_pkg::ed_ref) ? option_word : ref_value;
               next_digit = 2'd3;
            end else if (knob.short_press) begin
               if (digit == 2'd0) begin
                  // last digit: store, light all segments, leave
                  if (mode == strain_panel_pkg::ed_ref) next_ref_value = work;
                  else next_option_word = work;
                  next_all_segments = 1'b1;
                  next_mode         = strain_panel_pkg::ed_idle;
               end else begin
                  // more digits left: blink moves one lower
                  next_digit = digit - 2'd1;
               end
            end else if (knob.turn_step) begin
               // option digits: two switches, the gain code, then the point
               // only the blinking nibble is touched
               unique case (digit)
                  2'd3: next_work[15:12] = (mode == strain_panel_pkg::ed_ref)
                        ? step_digit(work[15:12], knob.turn_up, `REF_MAX_DIGIT)
                        : step_digit(work[15:12], knob.turn_up, 4'h1);
                  2'd2: next_work[11:8] = (mode == strain_panel_pkg::ed_ref)
                        ? step_digit(work[11:8], knob.turn_up, `REF_MAX_DIGIT)
                        : step_digit(work[11:8], knob.turn_up, 4'h1);
                  2'd1: next_work[7:4] = (mode == strain_panel_pkg::ed_ref)
                        ? step_digit(work[7:4], knob.turn_up, `REF_MAX_DIGIT)
                        : step_gain(work[7:4], knob.turn_up);
                  2'd0: next_work[3:0] = (mode == strain_panel_pkg::ed_ref)
                        ? step_digit(work[3:0], knob.turn_up, `REF_MAX_DIGIT)
                        : step_digit(work[3:0], knob.turn_up, `POINT_MAX);
               endcase
            end
         end
      endcase
   end

   // editor registers
   // reference resets to 2000, options to all off, digit to the top
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mode         <= strain_panel_pkg::ed_idle;
         digit        <= 2'd3;
         work         <= `REF_RESET_VALUE;
         ref_value    <= `REF_RESET_VALUE;
         option_word  <= `OPT_RESET_VALUE;
         all_segments <= 1'b0;
      end else begin
         mode         <= next_mode;
         digit        <= next_digit;
         work         <= next_work;
         ref_value    <= next_ref_value;
         option_word  <= next_option_word;
         all_segments <= next_all_segments;
      end
   end

   // blink timer, free running
   // limitation: not restarted on a digit move, so the first blink may be short
   // the phase flips each time the count wraps at BLINK_CYCLES
   // the counter runs through all modes; only the display uses the phase
   logic [$clog2(BLINK_CYCLES)-1:0] blink_count, next_blink_count;
   logic                            next_blink_phase;
   always_comb begin
      next_blink_count = blink_count + 1'b1;
      next_blink_phase = blink_phase;
      if (blink_count == ($clog2(BLINK_CYCLES))'(BLINK_CYCLES - 1)) begin
         next_blink_count = '0;
         next_blink_phase = ~blink_phase;
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         blink_count <= '0;
         blink_phase <= 1'b0;
      end else begin
         blink_count <= next_blink_count;
         blink_phase <= next_blink_phase;
      end
   end

   // display outputs from flops
   // built from next values so the display never lags the state by a cycle
   // idle shows the stored reference, editing shows the working digits
   // the point preview shows the candidate before it is stored
   logic [15:0] next_show_digits;
   logic [3:0]  next_blink_mask;
   logic        next_unit_lamp;
   logic [1:0]  next_shown_point;
   logic [15:0] next_ref_live;
   always_comb begin
      next_show_digits = (next_mode == strain_panel_pkg::ed_idle) ? next_ref_value : next_work;
      next_blink_mask  = (next_mode == strain_panel_pkg::ed_idle) ? 4'h0 : 4'h1 << next_digit;
      next_unit_lamp   = (next_mode == strain_panel_pkg::ed_ref);
      // while the point digit is edited, show the candidate position
      next_shown_point = (next_mode == strain_panel_pkg::ed_opt && next_digit == 2'd0)
                         ? next_work[1:0] : next_option_word[1:0];
      // injection follows the edit at once, not the stored value
      next_ref_live    = (next_mode == strain_panel_pkg::ed_ref) ? next_work : next_ref_value;
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         show_digits  <= `REF_RESET_VALUE;
         blink_mask   <= 4'h0;
         unit_lamp    <= 1'b0;
         shown_point  <= 2'd0;
         ref_live     <= `REF_RESET_VALUE;
      end else begin
         show_digits  <= next_show_digits;
         blink_mask   <= next_blink_mask;
         unit_lamp    <= next_unit_lamp;
         shown_point  <= next_shown_point;
         ref_live     <= next_ref_live;
      end
   end

   // decoded option fields
   // read from the stored word, so unstored edits do not leak out
   assign lead_drop_compensation = option_word[`OPT_COMP_POS];
   assign wiring_check           = option_word[`OPT_WIRE_POS];
   assign auto_gain_select       = option_word[`OPT_GAIN_POS +: 4];
   assign point_position         = option_word[`OPT_POINT_POS +: 2];

   // null sequencer; runs regardless of the editor
   // compensation is always visited so an off option can clear the old value
   // gain_ran remembers whether the gain stage ran in this pass
   // the sequencer reads the decoded options at each step
   strain_panel_pkg::null_state_t nstate, next_nstate;
   logic gain_ran, next_gain_ran;            // gain stage ran this pass
   logic gain_ok;
   // gain needs a voltage code and range at off
   assign gain_ok = (auto_gain_select != `GAIN_OFF) && sync_b[1];

   always_comb begin
      next_nstate   = nstate;
      next_gain_ran = gain_ran;
      unique case (nstate)
         strain_panel_pkg::nq_idle: begin
            // presses while busy are ignored: only idle looks at the edge
            if (null_press) begin
               next_gain_ran = 1'b0;
               // first enabled stage; compensation always runs so it can clear
               next_nstate = wiring_check ? strain_panel_pkg::nq_wire : strain_panel_pkg::nq_comp;
            end
         end
         // wiring check done, compensation next
         strain_panel_pkg::nq_wire: begin
            if (stage_done) next_nstate = strain_panel_pkg::nq_comp;
         end
         // gain only when both conditions hold, else straight to the null
         strain_panel_pkg::nq_comp: begin
            if (stage_done) begin
               next_nstate   = gain_ok ? strain_panel_pkg::nq_gain : strain_panel_pkg::nq_null;
               next_gain_ran = gain_ok;
            end
         end
         // gain done, the resistance null closes the pass
         strain_panel_pkg::nq_gain: begin
            if (stage_done) next_nstate = strain_panel_pkg::nq_null;
         end
         // pass complete, back to idle
         strain_panel_pkg::nq_null: begin
            if (stage_done) next_nstate = strain_panel_pkg::nq_idle;
         end
         // stray state codes recover to idle
         default: next_nstate = strain_panel_pkg::nq_idle;
      endcase
   end

   // stage command registered toward the engine
   // start pulses one cycle, on the same edge the stage is entered
   // clear_comp for every cycle of the compensation stage with the option off
   // keep_ref and with_ref follow the synchronised injection switch
   strain_panel_pkg::stage_cmd_t next_stage_cmd;
   always_comb begin
      next_stage_cmd       = '0;
      next_stage_cmd.start = (next_nstate != nstate) && (next_nstate != strain_panel_pkg::nq_idle);
      // compensation stage with option off only wipes the old value
      next_stage_cmd.clear_comp = (next_nstate == strain_panel_pkg::nq_comp) && !lead_drop_compensation;
      next_stage_cmd.keep_ref   = next_gain_ran && sync_b[0];
      next_stage_cmd.with_ref   = (next_nstate == strain_panel_pkg::nq_null)
                                  && !next_gain_ran && sync_b[0];
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         nstate    <= strain_panel_pkg::nq_idle;
         gain_ran  <= 1'b0;
         stage_cmd <= '0;
      end else begin
         nstate    <= next_nstate;
         gain_ran  <= next_gain_ran;
         stage_cmd <= next_stage_cmd;
      end
   end
   // stage and busy are plain decodes of the state register
   assign null_stage = nstate;
   assign null_busy  = (nstate != strain_panel_pkg::nq_idle);
endmodule // strain_panel_settings
`default_nettype wire

/* File: inc/strain_panel_consts.svh */
// constants for the strain panel settings controller
`ifndef STRAIN_PANEL_CONSTS_SVH
`define STRAIN_PANEL_CONSTS_SVH
`define REF_MAX_DIGIT      4'h9
`define REF_RESET_VALUE    16'h2000
`define OPT_RESET_VALUE    16'h0000
`define OPT_COMP_POS       12
`define OPT_WIRE_POS       8
`define OPT_GAIN_POS       4
`define OPT_POINT_POS      0
`define GAIN_OFF           4'h0
`define GAIN_5V            4'h5
`define GAIN_8V            4'h8
`define GAIN_10V           4'h1
`define POINT_MAX          4'h3
`define BLINK_HALF_NS      250000000
`define CLOCK_PERIOD_NS    40
`endif

/* File: inc/strain_panel_pkg.sv */
// types for the strain panel settings controller
package strain_panel_pkg;
   typedef enum logic [1:0] {
      ed_idle = 2'b00,
      ed_ref  = 2'b01,
      ed_opt  = 2'b10
   } editor_t;
   typedef enum logic [2:0] {
      nq_idle   = 3'b000,
      nq_wire   = 3'b001,
      nq_comp   = 3'b010,
      nq_gain   = 3'b011,
      nq_null   = 3'b100
   } null_state_t;
   typedef struct packed {
      logic       short_press;
      logic       long_press;
      logic       turn_step;
      logic       turn_up;
   } knob_t;
   typedef struct packed {
      logic       start;
      logic       clear_comp;
      logic       keep_ref;
      logic       with_ref;
   } stage_cmd_t;
endpackage

/* File: testbench/strain_panel_settings_props.sv */
// concurrent checks on the strain panel settings controller ports
`timescale 1ns/1ns
`default_nettype none
module strain_panel_settings_props (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          sys_rst,
   // knob and stage engine
   input  wire strain_panel_pkg::knob_t       knob,
   input  wire logic                          stage_done,
   input  wire strain_panel_pkg::null_state_t null_stage,
   input  wire strain_panel_pkg::stage_cmd_t  stage_cmd,
   // settings and display
   input  wire logic [15:0]                   ref_value,
   input  wire logic [15:0]                   ref_live,
   input  wire logic                          lead_drop_compensation,
   input  wire logic [3:0]                    auto_gain_select,
   input  wire logic [3:0]                    blink_mask,
   input  wire logic                          unit_lamp,
   input  wire logic                          all_segments
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // digits that a turn must not touch
   wire logic [15:0] keep_mask = ~{{4{blink_mask[3]}}, {4{blink_mask[2]}}, {4{blink_mask[1]}}, {4{blink_mask[0]}}};
   // plain short press, long press outranks it
   wire logic        short_only = knob.short_press && !knob.long_press;
   AST_ENTRY: assert property (short_only && blink_mask == 4'h0 |=> blink_mask == 4'h8 && unit_lamp)
      else $error("editor entry wrong");
   AST_DIGITS: assert property (ref_value[15:12] <= 4'h9 && ref_value[11:8] <= 4'h9 && ref_value[7:4] <= 4'h9 && ref_value[3:0] <= 4'h9)
      else $error("stored digit above nine");
   AST_MOVE: assert property (short_only && blink_mask inside {4'h8, 4'h4, 4'h2} |=> blink_mask == $past(blink_mask) >> 1)
      else $error("blink did not move down");
   AST_STORE: assert property (short_only && blink_mask == 4'h1 |=> all_segments && blink_mask == 4'h0)
      else $error("store did not finish");
   AST_TURN: assert property (knob.turn_step && !knob.short_press && !knob.long_press && unit_lamp && blink_mask != 4'h0
      |=> (ref_live & keep_mask) == ($past(ref_live) & $past(keep_mask)))
      else $error("turn touched another digit");
   AST_TOGGLE: assert property (knob.long_press && blink_mask != 4'h0 |=> unit_lamp != $past(unit_lamp) && blink_mask == 4'h8)
      else $error("long press did not toggle");
   AST_START: assert property ($changed(null_stage) && null_stage != strain_panel_pkg::nq_idle |-> stage_cmd.start)
      else $error("stage start missing");
   AST_ORDER: assert property (null_stage == strain_panel_pkg::nq_wire && stage_done |=> null_stage == strain_panel_pkg::nq_comp)
      else $error("wiring not followed by compensation");
   AST_SKIP: assert property (null_stage == strain_panel_pkg::nq_comp && stage_done && auto_gain_select == 4'h0
      |=> null_stage == strain_panel_pkg::nq_null)
      else $error("disabled gain stage not skipped");
   AST_CLEAR: assert property (stage_cmd.start && null_stage == strain_panel_pkg::nq_comp
      |-> stage_cmd.clear_comp == !lead_drop_compensation)
      else $error("compensation clear wrong");
endmodule // strain_panel_settings_props
bind strain_panel_settings strain_panel_settings_props chk (.clock(clock), .sys_rst(sys_rst), .knob(knob),
   .stage_done(stage_done), .null_stage(null_stage), .stage_cmd(stage_cmd), .ref_value(ref_value),
   .ref_live(ref_live), .lead_drop_compensation(lead_drop_compensation), .auto_gain_select(auto_gain_select),
   .blink_mask(blink_mask), .unit_lamp(unit_lamp), .all_segments(all_segments));
`default_nettype wire

/* File: testbench/panel_operator.sv */
// operator at the knob and the null button
`timescale 1ns/1ns
`default_nettype none
module panel_operator (
   // bench clock
   input  wire logic              clock,
   // hand actions
   output strain_panel_pkg::knob_t knob,
   output logic                   null_button
);
   // hands off the panel at start
   initial begin
      knob = '0;
      null_button = 1'b0;
   end
   // one debounced event lasting one cycle
   task automatic pulse(input logic s, input logic l, input logic t, input logic up);
      @(negedge clock);
      knob <= {s, l, t, up};
      @(negedge clock);
      knob <= '0;
   endtask
   // short tap, the sync chain still sees the rising edge
   task automatic push_null();
      @(negedge clock);
      null_button <= 1'b1;
      @(negedge clock);
      null_button <= 1'b0;
   endtask
endmodule // panel_operator
`default_nettype wire

/* File: testbench/strain_panel_settings_bench.sv */
// self-checking bench for the strain panel settings controller
`timescale 1ns/1ns
`default_nettype none
module strain_panel_settings_bench;
   logic                          clock = 1'b0;
   logic                          sys_rst = 1'b1;
   strain_panel_pkg::knob_t       knob;
   logic                          null_button;
   logic                          range_is_off = 1'b0;
   logic                          ref_inject_on = 1'b0;
   logic                          stage_done = 1'b0;
   strain_panel_pkg::null_state_t null_stage;
   strain_panel_pkg::stage_cmd_t  stage_cmd;
   logic                          null_busy, lead_drop_compensation, wiring_check, unit_lamp, all_segments;
   logic                          blink_phase;
   logic [15:0]                   ref_value, ref_live, option_word, show_digits;
   logic [3:0]                    auto_gain_select, blink_mask;
   logic [1:0]                    point_position, shown_point;
   int                            fail_count = 0;
   int                            checks = 0;
   // 25 MHz clock
   always #20 clock = ~clock;
   panel_operator op (.clock, .knob, .null_button);
   strain_panel_settings #(.BLINK_CYCLES(4)) uut (.clock, .sys_rst, .knob, .null_button, .range_is_off,
      .ref_inject_on, .stage_done, .null_stage, .stage_cmd, .null_busy, .ref_value, .ref_live, .option_word,
      .lead_drop_compensation, .wiring_check, .auto_gain_select, .point_position, .show_digits,
      .blink_mask, .blink_phase, .unit_lamp, .all_segments, .shown_point);
   // verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // bounded wait for a stage; returns in its entry cycle, while start stands
   task automatic walk(input strain_panel_pkg::null_state_t st);
      int n;
      n = 0;
      while (null_stage !== st && n < 20) begin
         @(negedge clock);
         n++;
      end
      if (null_stage !== st) begin
         fail_count++;
         report_and_stop();
      end
   endtask
   // stage engine reports completion
   task automatic finish_stage();
      stage_done = 1'b1;
      @(negedge clock);
      stage_done = 1'b0;
   endtask
   task automatic t_ref_edit();
      op.pulse(1, 0, 0, 0);
      check("blink", {12'h000, blink_mask}, 16'h0008);
      check("lamp", {15'h0000, unit_lamp}, 16'h0001);
      repeat (3) op.pulse(0, 0, 1, 1);
      check("live", ref_live, 16'h5000);
      check("stored", ref_value, 16'h2000);
      check("shown", show_digits, 16'h5000);
      op.pulse(1, 0, 0, 0);
      check("blink", {12'h000, blink_mask}, 16'h0004);
      repeat (9) op.pulse(0, 0, 1, 1);
      check("live", ref_live, 16'h5900);
      op.pulse(0, 0, 1, 1);
      check("live", ref_live, 16'h5000);
      repeat (2) op.pulse(1, 0, 0, 0);
      op.pulse(0, 0, 1, 1);
      check("live", ref_live, 16'h5001);
      op.pulse(1, 0, 0, 0);
      check("stored", ref_value, 16'h5001);
      check("segments", {15'h0000, all_segments}, 16'h0001);
      check("shown", show_digits, 16'h5001);
   endtask
   task automatic t_opt_edit();
      op.pulse(1, 0, 0, 0);
      op.pulse(0, 1, 0, 0);
      check("lamp", {15'h0000, unit_lamp}, 16'h0000);
      check("blink", {12'h000, blink_mask}, 16'h0008);
      op.pulse(0, 0, 1, 1);
      repeat (2) op.pulse(1, 0, 0, 0);
      repeat (2) op.pulse(0, 0, 1, 1);
      op.pulse(1, 0, 0, 0);
      repeat (3) op.pulse(0, 0, 1, 1);
      check("point shown", {14'h0000, shown_point}, 16'h0003);
      op.pulse(1, 0, 0, 0);
      check("options", option_word, 16'h1083);
      check("fields", {8'h00, lead_drop_compensation, wiring_check, auto_gain_select,
         point_position}, 16'h00A3);
   endtask
   task automatic t_null_gain();
      range_is_off = 1'b1;
      ref_inject_on = 1'b1;
      repeat (3) @(negedge clock);
      op.push_null();
      walk(strain_panel_pkg::nq_comp);
      check("comp start", {14'h0000, stage_cmd.start, stage_cmd.clear_comp}, 16'h0002);
      finish_stage();
      walk(strain_panel_pkg::nq_gain);
      check("gain start", {15'h0000, stage_cmd.start}, 16'h0001);
      finish_stage();
      walk(strain_panel_pkg::nq_null);
      check("null cmd", {12'h000, stage_cmd}, 16'h000A);
      finish_stage();
      walk(strain_panel_pkg::nq_idle);
      check("busy", {15'h0000, null_busy}, 16'h0000);
   endtask
   task automatic t_null_editing();
      range_is_off = 1'b0;
      repeat (3) @(negedge clock);
      op.pulse(1, 0, 0, 0);
      op.push_null();
      walk(strain_panel_pkg::nq_comp);
      check("busy", {15'h0000, null_busy}, 16'h0001);
      finish_stage();
      walk(strain_panel_pkg::nq_null);
      check("null cmd", {12'h000, stage_cmd}, 16'h0009);
      check("blink", {12'h000, blink_mask}, 16'h0008);
      finish_stage();
      walk(strain_panel_pkg::nq_idle);
   endtask
   // options to compensation off, wiring on, gain off; then a null pass
   task automatic t_null_skip();
      op.pulse(0, 1, 0, 0);
      op.pulse(0, 0, 1, 0);
      op.pulse(1, 0, 0, 0);
      op.pulse(0, 0, 1, 1);
      op.pulse(1, 0, 0, 0);
      repeat (2) op.pulse(0, 0, 1, 1);
      repeat (2) op.pulse(1, 0, 0, 0);
      check("options", option_word, 16'h0103);
      op.push_null();
      walk(strain_panel_pkg::nq_wire);
      check("wire start", {14'h0000, stage_cmd.start, stage_cmd.clear_comp}, 16'h0002);
      finish_stage();
      walk(strain_panel_pkg::nq_comp);
      check("comp clear", {14'h0000, stage_cmd.start, stage_cmd.clear_comp}, 16'h0003);
      finish_stage();
      walk(strain_panel_pkg::nq_null);
      check("null cmd", {12'h000, stage_cmd}, 16'h0009);
      finish_stage();
      walk(strain_panel_pkg::nq_idle);
   endtask
   // main sequence
   initial begin
      repeat (6) @(negedge clock);
      sys_rst = 1'b0;
      @(negedge clock);
      check("stored", ref_value, 16'h2000);
      check("options", option_word, 16'h0000);
      check("phase", {15'h0000, blink_phase}, 16'h0000);
      repeat (3) @(negedge clock);
      check("phase", {15'h0000, blink_phase}, 16'h0001);
      t_ref_edit();
      t_opt_edit();
      t_null_gain();
      t_null_editing();
      t_null_skip();
      report_and_stop();
   end
endmodule // strain_panel_settings_bench
`default_nettype wire
